// [logic/lcs_pkg.sv]
// Shared types and constants of the link-control service block.
// Assumes one 25 MHz clock and a synchronous active-high reset.
`default_nettype none
package lcs_pkg;
    // ***********************
    // Widths and counts
    // ***********************
    localparam int LCS_AP_W = 6;
    localparam int LCS_ADDR_W = 16;
    localparam int LCS_DATA_W = 32;
    localparam int LCS_INV_N = 4;
    localparam int LCS_GROUP_BIT = 15;
    localparam logic [3:0] LCS_TRIES_RST = 4'h0;

    // ***********************
    // Access classes
    // ***********************
    localparam logic [2:0] LCS_CLASS_URGENT = 3'h6;
    localparam logic [2:0] LCS_CLASS_NORMAL = 3'h4;
    localparam logic [2:0] LCS_CLASS_ROUTINE = 3'h2;
    localparam logic [2:0] LCS_CLASS_BULK = 3'h0;

    // ***********************
    // Enumerations
    // ***********************
    typedef enum logic [1:0] {
        LCS_SVC_ACKED = 2'h0,
        LCS_SVC_UNACKED = 2'h1,
        LCS_SVC_REPLY = 2'h2
    } lcs_svc_t;

    typedef enum logic [2:0] {
        LCS_FR_DATA_ACK = 3'h0,
        LCS_FR_DATA = 3'h1,
        LCS_FR_REPLY_REQ = 3'h2,
        LCS_FR_REPLY_RSP = 3'h3,
        LCS_FR_REPLY_NONE = 3'h4
    } lcs_frame_kind_t;

    typedef enum logic [2:0] {
        LCS_MAC_ACK = 3'h0,
        LCS_MAC_NOACK = 3'h1,
        LCS_MAC_DONE = 3'h2,
        LCS_MAC_REPLY = 3'h3,
        LCS_MAC_NO_DATA = 3'h4,
        LCS_MAC_TXERR = 3'h5,
        LCS_MAC_OFFLINE = 3'h6
    } lcs_mac_code_t;

    typedef enum logic [3:0] {
        LCS_ST_OK = 4'h0,
        LCS_ST_NO_ACK_AFTER_RETRIES = 4'h1,
        LCS_ST_STATION_OFF_LINE = 4'h2,
        LCS_ST_INVALID_PARAM = 4'h3,
        LCS_ST_NOT_AVAILABLE = 4'h4
    } lcs_status_t;

    // Gray along idle, send, wait, confirm
    typedef enum logic [1:0] {
        LCS_IDLE = 2'b00,
        LCS_SEND = 2'b01,
        LCS_WAIT = 2'b11,
        LCS_CONFIRM = 2'b10
    } lcs_state_t;

    // ***********************
    // Carriers
    // ***********************
    typedef struct packed {
        lcs_svc_t svc;
        logic [LCS_AP_W-1:0] source_access_point;
        logic [LCS_AP_W-1:0] dest_access_point;
        logic [LCS_ADDR_W-1:0] remote;
        logic [2:0] sclass;
        logic [LCS_DATA_W-1:0] data;
    } lcs_req_t;

    typedef struct packed {
        lcs_frame_kind_t kind;
        logic seq;
        logic [3:0] attempts;
        logic [LCS_AP_W-1:0] source_access_point;
        logic [LCS_AP_W-1:0] dest_access_point;
        logic [LCS_ADDR_W-1:0] remote;
        logic [2:0] sclass;
        logic [LCS_DATA_W-1:0] data;
    } lcs_frame_t;

    typedef struct packed {
        lcs_frame_t frame;
        logic fcs_ok;
    } lcs_rx_t;

    typedef struct packed {
        lcs_mac_code_t code;
        logic [LCS_DATA_W-1:0] data;
    } lcs_mac_cfm_t;

    typedef struct packed {
        lcs_svc_t svc;
        lcs_status_t status;
        logic permanent;
        logic [LCS_DATA_W-1:0] data;
        logic [LCS_AP_W-1:0] source_access_point;
        logic [LCS_AP_W-1:0] dest_access_point;
        logic [LCS_ADDR_W-1:0] remote;
        logic [2:0] sclass;
    } lcs_cfm_t;
endpackage
`default_nettype wire

// [logic/lcs_buf2.sv]
// Two-entry frame buffer between the service logic and the access layer.
// Assumes the drain side may stall for any number of cycles.
`default_nettype none
module lcs_buf2 (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire lcs_pkg::lcs_frame_t in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output lcs_pkg::lcs_frame_t out_data_o,
    input wire logic out_ready_i
);
    import lcs_pkg::*;

    // ***********************
    // Storage
    // ***********************
    lcs_frame_t slot1;
    logic vld1;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // Ready is a flop: full means slot1 holds a word
    assign in_ready_o = !vld1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            vld1 <= 1'b0;
        end else begin
            if (pop) begin
                out_valid_o <= vld1 || push;
                vld1 <= 1'b0;
            end else if (push) begin
                out_valid_o <= 1'b1;
                vld1 <= out_valid_o;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (pop) begin
            out_data_o <= vld1 ? slot1 : in_data_i;
        end else if (push && !out_valid_o) begin
            out_data_o <= in_data_i;
        end
        if (push && out_valid_o && !pop) begin
            slot1 <= in_data_i;
        end
    end
endmodule // lcs_buf2
`default_nettype wire

// [logic/lcs_link_ctrl.sv]
// Link-control service logic between a local user and the access layer.
// Assumes the access layer retransmits on its own and reports one outcome
// per frame; received frames arrive with a check result already worked out.
`default_nettype none
module lcs_link_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // User requests
    input wire logic req_valid_i,
    input wire lcs_pkg::lcs_req_t req_i,
    output logic [lcs_pkg::LCS_INV_N-1:0] req_ready_o,
    input wire logic [3:0] attempts_max_i,
    // User confirmations
    output logic cfm_valid_o,
    output lcs_pkg::lcs_cfm_t cfm_o,
    // Indications to the user
    output logic ind_valid_o,
    output lcs_pkg::lcs_frame_t ind_o,
    // Reply buffer update
    input wire logic upd_valid_i,
    input wire logic [lcs_pkg::LCS_DATA_W-1:0] upd_data_i,
    output logic upd_cfm_o,
    // Access layer transmit
    output logic tx_valid_o,
    output lcs_pkg::lcs_frame_t tx_o,
    input wire logic tx_ready_i,
    // Access layer outcome and receive
    input wire logic mac_cfm_valid_i,
    input wire lcs_pkg::lcs_mac_cfm_t mac_cfm_i,
    input wire logic rx_valid_i,
    input wire lcs_pkg::lcs_rx_t rx_i
);
    import lcs_pkg::*;

    // ***********************
    // Declarations
    // ***********************
    lcs_state_t state;
    lcs_frame_t cur;
    lcs_svc_t cur_svc;
    logic cur_rsp;
    logic [3:0] tries;
    logic [LCS_INV_N-1:0] seq_bit;
    logic [LCS_DATA_W-1:0] reply_buf;
    logic reply_avail;
    logic rsp_pend;
    lcs_frame_t rsp_frame;
    logic dup_vld;
    logic dup_seq;
    logic [LCS_ADDR_W-1:0] dup_src;
    logic buf_ready;
    logic [1:0] req_inv;
    logic accept;
    logic bad_addr;
    logic rx_good;
    logic rx_dup;
    lcs_frame_kind_t rx_kind;

    // Class 0,2,4,6 maps onto invocation 0..3
    assign req_inv = req_i.sclass[2:1];
    assign accept = req_valid_i && req_ready_o[req_inv];
    assign bad_addr = (req_i.svc == LCS_SVC_ACKED) && req_i.remote[LCS_GROUP_BIT];
    assign rx_kind = rx_i.frame.kind;
    assign rx_good = rx_valid_i && rx_i.fcs_ok;
    assign rx_dup = dup_vld && (dup_src == rx_i.frame.remote) && (dup_seq == rx_i.frame.seq);

    // ***********************
    // Ready per invocation
    // ***********************
    // Single shared engine keeps the medium free during an exchange
    generate
        for (genvar i = 0; i < LCS_INV_N; i++) begin : g_inv
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    req_ready_o[i] <= 1'b0;
                    seq_bit[i] <= 1'b0;
                end else begin
                    req_ready_o[i] <= (state == LCS_IDLE) && !accept && !rsp_pend;
                    if (accept && req_inv == 2'(i) && req_i.svc == LCS_SVC_ACKED && !bad_addr) begin
                        seq_bit[i] <= !seq_bit[i];
                    end
                end
            end
        end
    endgenerate

    // ***********************
    // Transaction engine
    // ***********************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= LCS_IDLE;
            cur_rsp <= 1'b0;
            cur_svc <= LCS_SVC_ACKED;
            tries <= LCS_TRIES_RST;
            cfm_valid_o <= 1'b0;
        end else begin
            cfm_valid_o <= 1'b0;
            case (state)
                LCS_IDLE: begin
                    tries <= LCS_TRIES_RST;
                    // Answer unless a take lands; waiting on idle valid could stall forever
                    if (rsp_pend && !accept) begin
                        cur_rsp <= 1'b1;
                        state <= LCS_SEND;
                    end else if (accept) begin
                        cur_rsp <= 1'b0;
                        cur_svc <= req_i.svc;
                        if (bad_addr) begin
                            state <= LCS_CONFIRM;
                        end else begin
                            state <= LCS_SEND;
                        end
                    end
                end
                LCS_SEND: begin
                    if (buf_ready) begin
                        state <= LCS_WAIT;
                    end
                end
                LCS_WAIT: begin
                    if (mac_cfm_valid_i) begin
                        if (cur_rsp) begin
                            state <= LCS_IDLE;
                        end else if (cur_svc == LCS_SVC_REPLY &&
                                     mac_cfm_i.code == LCS_MAC_TXERR &&
                                     tries < attempts_max_i) begin
                            tries <= tries + 4'h1;
                            state <= LCS_SEND;
                        end else begin
                            cfm_valid_o <= 1'b1;
                            state <= LCS_IDLE;
                        end
                    end
                end
                LCS_CONFIRM: begin
                    cfm_valid_o <= 1'b1;
                    state <= LCS_IDLE;
                end
                default: begin
                    state <= LCS_IDLE;
                end
            endcase
        end
    end

    // Frame to send, built at acceptance
    always_ff @(posedge clk_i) begin
        if (state == LCS_IDLE && rsp_pend && !accept) begin
            cur <= rsp_frame;
        end else if (accept) begin
            cur.kind <= (req_i.svc == LCS_SVC_ACKED) ? LCS_FR_DATA_ACK :
                        (req_i.svc == LCS_SVC_UNACKED) ? LCS_FR_DATA : LCS_FR_REPLY_REQ;
            cur.seq <= seq_bit[req_inv];
            cur.attempts <= attempts_max_i;
            cur.source_access_point <= req_i.source_access_point;
            cur.dest_access_point <= req_i.dest_access_point;
            cur.remote <= req_i.remote;
            cur.sclass <= req_i.sclass;
            cur.data <= req_i.data;
        end
    end

    // ***********************
    // Confirmation contents
    // ***********************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfm_o <= '0;
        end else if (state == LCS_IDLE && accept) begin
            cfm_o.svc <= req_i.svc;
            cfm_o.status <= LCS_ST_INVALID_PARAM;
            cfm_o.permanent <= 1'b1;
            cfm_o.data <= '0;
            cfm_o.source_access_point <= req_i.source_access_point;
            cfm_o.dest_access_point <= req_i.dest_access_point;
            cfm_o.remote <= req_i.remote;
            cfm_o.sclass <= req_i.sclass;
        end else if (state == LCS_WAIT && mac_cfm_valid_i && !cur_rsp) begin
            cfm_o.permanent <= 1'b0;
            case (mac_cfm_i.code)
                LCS_MAC_ACK: cfm_o.status <= (cur_svc == LCS_SVC_ACKED) ? LCS_ST_OK :
                                            LCS_ST_NO_ACK_AFTER_RETRIES;
                LCS_MAC_DONE: cfm_o.status <= (cur_svc == LCS_SVC_UNACKED) ? LCS_ST_OK :
                                             LCS_ST_NO_ACK_AFTER_RETRIES;
                LCS_MAC_REPLY: begin
                    cfm_o.status <= LCS_ST_OK;
                    cfm_o.data <= mac_cfm_i.data;
                end
                LCS_MAC_NO_DATA: cfm_o.status <= LCS_ST_NOT_AVAILABLE;
                LCS_MAC_OFFLINE: begin
                    cfm_o.status <= LCS_ST_STATION_OFF_LINE;
                    cfm_o.permanent <= 1'b1;
                end
                default: cfm_o.status <= LCS_ST_NO_ACK_AFTER_RETRIES;
            endcase
        end
    end

    // ***********************
    // Receive path
    // ***********************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ind_valid_o <= 1'b0;
            ind_o <= '0;
            dup_vld <= 1'b0;
            dup_seq <= 1'b0;
            dup_src <= '0;
        end else begin
            ind_valid_o <= 1'b0;
            if (rx_good) begin
                if (rx_kind == LCS_FR_DATA_ACK) begin
                    dup_vld <= 1'b1;
                    dup_seq <= rx_i.frame.seq;
                    dup_src <= rx_i.frame.remote;
                    ind_valid_o <= !rx_dup;
                end else begin
                    ind_valid_o <= (rx_kind == LCS_FR_DATA) || (rx_kind == LCS_FR_REPLY_REQ);
                end
                ind_o <= rx_i.frame;
            end
        end
    end

    // Answering side: reply buffer and pending answer
    // Only one answer held; a second request overwrites an unsent one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reply_buf <= '0;
            reply_avail <= 1'b0;
            upd_cfm_o <= 1'b0;
            rsp_pend <= 1'b0;
            rsp_frame <= '0;
        end else begin
            upd_cfm_o <= upd_valid_i;
            if (upd_valid_i) begin
                reply_buf <= upd_data_i;
                reply_avail <= 1'b1;
            end
            if (rx_good && rx_kind == LCS_FR_REPLY_REQ) begin
                rsp_pend <= 1'b1; // Set wins over the take below
                rsp_frame <= rx_i.frame;
                rsp_frame.kind <= reply_avail ? LCS_FR_REPLY_RSP : LCS_FR_REPLY_NONE;
                rsp_frame.data <= reply_buf;
            end else if (state == LCS_IDLE && rsp_pend && !accept) begin
                rsp_pend <= 1'b0;
            end
        end
    end

    // ***********************
    // Transmit buffer
    // ***********************
    lcs_buf2 u_txbuf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(state == LCS_SEND),
        .in_data_i(cur),
        .in_ready_o(buf_ready),
        .out_valid_o(tx_valid_o),
        .out_data_o(tx_o),
        .out_ready_i(tx_ready_i)
    );
endmodule // lcs_link_ctrl
`default_nettype wire

// [test/lcs_link_ctrl_monitor.sv]
// Assertion checker for the link-control service block.
// Assumes it is bound to lcs_link_ctrl and sees only that module's ports.
`default_nettype none
module lcs_link_ctrl_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // User side
    input wire logic req_valid_i,
    input wire lcs_pkg::lcs_req_t req_i,
    input wire logic [lcs_pkg::LCS_INV_N-1:0] req_ready_o,
    input wire logic cfm_valid_o,
    input wire lcs_pkg::lcs_cfm_t cfm_o,
    input wire logic ind_valid_o,
    input wire lcs_pkg::lcs_frame_t ind_o,
    input wire logic upd_valid_i,
    input wire logic upd_cfm_o,
    // Access layer side
    input wire logic tx_valid_o,
    input wire lcs_pkg::lcs_frame_t tx_o,
    input wire logic tx_ready_i,
    input wire logic mac_cfm_valid_i,
    input wire lcs_pkg::lcs_mac_cfm_t mac_cfm_i,
    input wire logic rx_valid_i,
    input wire lcs_pkg::lcs_rx_t rx_i
);
    timeunit 1ns;
    timeprecision 1ns;
    import lcs_pkg::*;
    logic take;
    logic grp_ack;
    assign take = req_valid_i && req_ready_o[req_i.sclass[2:1]];
    assign grp_ack = req_i.svc == LCS_SVC_ACKED && req_i.remote[LCS_GROUP_BIT];

    // ***********************
    // Assertions
    // ***********************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_busy_drops_ready: assert property (take |=> req_ready_o == '0)
        else $error("ready stayed up after a take");
    chk_cfm_single: assert property (cfm_valid_o |=> !cfm_valid_o)
        else $error("confirm longer than one cycle");
    chk_cfm_cause: assert property (cfm_valid_o && cfm_o.status != LCS_ST_INVALID_PARAM
        |-> $past(mac_cfm_valid_i)) else $error("confirm without outcome");
    chk_ok_needs_ack: assert property (cfm_valid_o && cfm_o.svc == LCS_SVC_ACKED
        && cfm_o.status == LCS_ST_OK |-> $past(mac_cfm_valid_i && mac_cfm_i.code == LCS_MAC_ACK))
        else $error("positive confirm without acknowledgment");
    chk_group_refused: assert property (take && grp_ack |-> ##2 cfm_valid_o
        && cfm_o.status == LCS_ST_INVALID_PARAM && cfm_o.permanent)
        else $error("group address not refused");
    chk_perm_class: assert property (cfm_valid_o |-> cfm_o.permanent ==
        (cfm_o.status inside {LCS_ST_STATION_OFF_LINE, LCS_ST_INVALID_PARAM}))
        else $error("wrong permanent flag");
    chk_ind_good: assert property (ind_valid_o |-> $past(rx_valid_i && rx_i.fcs_ok)
        && ind_o.data == $past(rx_i.frame.data)) else $error("bad indication");
    chk_upd_answer: assert property (upd_valid_i |=> upd_cfm_o)
        else $error("update not confirmed");
    chk_tx_holds: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
        else $error("frame changed before taken");
    chk_send_starts: assert property (take && !grp_ack |-> ##[1:3] tx_valid_o)
        else $error("no frame after request");
endmodule // lcs_link_ctrl_monitor

bind lcs_link_ctrl lcs_link_ctrl_monitor i_lcs_link_ctrl_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .cfm_valid_o(cfm_valid_o), .cfm_o(cfm_o),
    .ind_valid_o(ind_valid_o), .ind_o(ind_o), .upd_valid_i(upd_valid_i), .upd_cfm_o(upd_cfm_o),
    .tx_valid_o(tx_valid_o), .tx_o(tx_o), .tx_ready_i(tx_ready_i),
    .mac_cfm_valid_i(mac_cfm_valid_i), .mac_cfm_i(mac_cfm_i), .rx_valid_i(rx_valid_i), .rx_i(rx_i)
);
`default_nettype wire

// [test/lcs_mac_model.sv]
// Access layer stand-in: takes one frame, answers with the commanded code.
// Assumes the bench sets the code and reply word before each request.
`default_nettype none
module lcs_mac_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Frames from the block
    input wire logic tx_valid_i,
    input wire lcs_pkg::lcs_frame_t tx_i,
    output logic tx_ready_o,
    // Outcome back to the block
    output logic mac_cfm_valid_o,
    output lcs_pkg::lcs_mac_cfm_t mac_cfm_o,
    // Bench control and observation
    input wire lcs_pkg::lcs_mac_code_t code_i,
    input wire logic [lcs_pkg::LCS_DATA_W-1:0] data_i,
    input wire logic slow_i,
    output lcs_pkg::lcs_frame_t last_o,
    output logic [7:0] tx_cnt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import lcs_pkg::*;
    logic busy;
    logic [2:0] wait_cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_ready_o <= 1'b0;
            mac_cfm_valid_o <= 1'b0;
            mac_cfm_o <= '0;
            busy <= 1'b0;
            wait_cnt <= 3'h0;
            last_o <= '0;
            tx_cnt_o <= 8'h00;
        end else begin
            mac_cfm_valid_o <= 1'b0;
            // Idle outcome word toggles so stale data is never mistaken for valid
            mac_cfm_o.data <= ~mac_cfm_o.data;
            if (busy) begin
                tx_ready_o <= 1'b0;
                if (wait_cnt == 3'h0) begin
                    busy <= 1'b0;
                    mac_cfm_valid_o <= 1'b1;
                    mac_cfm_o <= '{code_i, data_i};
                end else begin
                    wait_cnt <= wait_cnt - 3'h1;
                end
            end else if (tx_valid_i && tx_ready_o) begin
                // One frame on the line until its outcome is known
                busy <= 1'b1;
                tx_ready_o <= 1'b0;
                last_o <= tx_i;
                tx_cnt_o <= tx_cnt_o + 8'h01;
                wait_cnt <= slow_i ? 3'h5 : 3'h0;
            end else begin
                tx_ready_o <= slow_i ? 1'($urandom_range(0, 1)) : 1'b1;
            end
        end
    end
endmodule // lcs_mac_model
`default_nettype wire

// [test/tb_lcs_link_ctrl.sv]
// Self-checking bench for the link-control service block.
// Assumes lcs_mac_model stands in for the access layer.
`default_nettype none
module tb_lcs_link_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import lcs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid, upd_valid, rx_valid, slow, cfm_valid, ind_valid, upd_cfm, tx_valid;
    logic tx_ready, mcv;
    lcs_req_t req;
    lcs_cfm_t cfm;
    lcs_frame_t ind, tx, last;
    lcs_rx_t rx;
    lcs_mac_cfm_t mc;
    lcs_mac_code_t mac_code;
    logic [3:0] req_ready, attempts;
    logic [31:0] upd_data, mac_data, w;
    logic [7:0] tx_cnt, n0;
    int err_count = 0;
    int samples_checked = 0;
    int unsigned seed;
    logic [2:0] cls [4] = '{LCS_CLASS_URGENT, LCS_CLASS_NORMAL, LCS_CLASS_ROUTINE, LCS_CLASS_BULK};
    lcs_svc_t svcs [7] = '{LCS_SVC_ACKED, LCS_SVC_ACKED, LCS_SVC_ACKED, LCS_SVC_UNACKED,
        LCS_SVC_REPLY, LCS_SVC_REPLY, LCS_SVC_REPLY};
    lcs_mac_code_t codes [7] = '{LCS_MAC_ACK, LCS_MAC_NOACK, LCS_MAC_OFFLINE, LCS_MAC_DONE,
        LCS_MAC_REPLY, LCS_MAC_NO_DATA, LCS_MAC_TXERR};

    always #20 clk = ~clk;

    lcs_link_ctrl i_lcs_link_ctrl (
        .clk_i(clk), .rst_i(rst), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
        .attempts_max_i(attempts), .cfm_valid_o(cfm_valid), .cfm_o(cfm), .ind_valid_o(ind_valid),
        .ind_o(ind), .upd_valid_i(upd_valid), .upd_data_i(upd_data), .upd_cfm_o(upd_cfm),
        .tx_valid_o(tx_valid), .tx_o(tx), .tx_ready_i(tx_ready), .mac_cfm_valid_i(mcv),
        .mac_cfm_i(mc), .rx_valid_i(rx_valid), .rx_i(rx)
    );
    lcs_mac_model i_lcs_mac_model (
        .clk_i(clk), .rst_i(rst), .tx_valid_i(tx_valid), .tx_i(tx), .tx_ready_o(tx_ready),
        .mac_cfm_valid_o(mcv), .mac_cfm_o(mc), .code_i(mac_code), .data_i(mac_data),
        .slow_i(slow), .last_o(last), .tx_cnt_o(tx_cnt)
    );

    // ***********************
    // Checks and expectations
    // ***********************
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask

    function automatic lcs_status_t exp_st(lcs_svc_t s, lcs_mac_code_t c, logic grp);
        if (s == LCS_SVC_ACKED && grp) return LCS_ST_INVALID_PARAM;
        if (c == LCS_MAC_OFFLINE) return LCS_ST_STATION_OFF_LINE;
        if (c == LCS_MAC_NO_DATA) return LCS_ST_NOT_AVAILABLE;
        if ((s == LCS_SVC_ACKED && c == LCS_MAC_ACK) || (s == LCS_SVC_UNACKED && c == LCS_MAC_DONE)
            || (s == LCS_SVC_REPLY && c == LCS_MAC_REPLY)) return LCS_ST_OK;
        return LCS_ST_NO_ACK_AFTER_RETRIES;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ***********************
    // Stimulus tasks
    // ***********************
    task automatic do_req(input lcs_svc_t s, input lcs_mac_code_t c, input logic grp);
        lcs_req_t r;
        lcs_status_t st;
        int i;
        // Class only from the recommended set, one invocation each
        r = '{s, 6'($urandom), 6'($urandom), 16'($urandom), cls[$urandom_range(0, 3)], $urandom};
        r.remote[LCS_GROUP_BIT] = grp;
        st = exp_st(s, c, grp);
        @(negedge clk);
        mac_code = c;
        mac_data = $urandom;
        attempts = 4'($urandom_range(1, 3));
        n0 = tx_cnt;
        req = r;
        req_valid = 1'b1;
        for (i = 0; i < 200 && req_ready[r.sclass[2:1]] !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        req = ~r;
        for (i = 0; i < 400 && cfm_valid !== 1'b1; i++) begin
            check(req_ready, 4'h0);
            @(negedge clk);
        end
        check(cfm_valid, 1'b1);
        check(cfm.status, st);
        check(cfm.permanent, st inside {LCS_ST_STATION_OFF_LINE, LCS_ST_INVALID_PARAM});
        check({cfm.svc, cfm.source_access_point, cfm.dest_access_point, cfm.remote, cfm.sclass},
            {s, r.source_access_point, r.dest_access_point, r.remote, r.sclass});
        if (s == LCS_SVC_REPLY && st == LCS_ST_OK) check(cfm.data, mac_data);
        if (st == LCS_ST_INVALID_PARAM) check(tx_cnt, n0);
        else check({last.kind, last.remote, last.data}, {lcs_frame_kind_t'(s), r.remote,
            r.data});
    endtask

    task automatic do_rx(input lcs_frame_kind_t k, input logic sq, input logic ok, input logic e);
        logic seen;
        @(negedge clk);
        w = $urandom;
        rx = '0;
        rx.frame.kind = k;
        rx.frame.seq = sq;
        rx.frame.remote = 16'h0123;
        rx.frame.data = w;
        rx.fcs_ok = ok;
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
        rx = ~rx;
        seen = ind_valid;
        @(negedge clk);
        seen = seen | ind_valid;
        check(seen, e);
        if (e) check(ind.data, w);
    endtask

    // ***********************
    // Main sequence
    // ***********************
    initial begin
        seed = $urandom(32'h068f);
        {req_valid, upd_valid, rx_valid, slow} = 4'h0;
        req = '0;
        rx = '0;
        upd_data = 32'h0;
        mac_code = LCS_MAC_ACK;
        mac_data = 32'h0;
        attempts = 4'h1;
        repeat (2) @(negedge clk);
        check(req_ready, 4'h0);
        rst = 1'b0;
        @(negedge clk);
        check(req_ready, 4'hf);
        // Later rounds stall the access layer to exercise the buffer
        for (int k = 0; k < 21; k++) begin
            slow = (k >= 7);
            do_req(svcs[k % 7], codes[k % 7], 1'b0);
        end
        do_req(LCS_SVC_ACKED, LCS_MAC_ACK, 1'b1);
        do_req(LCS_SVC_UNACKED, LCS_MAC_DONE, 1'b1);
        do_rx(LCS_FR_DATA_ACK, 1'b0, 1'b1, 1'b1);
        do_rx(LCS_FR_DATA_ACK, 1'b0, 1'b1, 1'b0);
        do_rx(LCS_FR_DATA, 1'b0, 1'b0, 1'b0);
        do_rx(LCS_FR_DATA_ACK, 1'b1, 1'b1, 1'b1);
        do_rx(LCS_FR_DATA, 1'b1, 1'b1, 1'b1);
        // No update yet, so the answer must say the data is absent
        n0 = tx_cnt;
        do_rx(LCS_FR_REPLY_REQ, 1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 200 && tx_cnt === n0; i++) @(negedge clk);
        check(last.kind, LCS_FR_REPLY_NONE);
        repeat (4) @(negedge clk);
        upd_data = $urandom;
        upd_valid = 1'b1;
        @(negedge clk);
        upd_valid = 1'b0;
        check(upd_cfm, 1'b1);
        n0 = tx_cnt;
        do_rx(LCS_FR_REPLY_REQ, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 200 && tx_cnt === n0; i++) @(negedge clk);
        check({last.kind, last.data}, {LCS_FR_REPLY_RSP, upd_data});
        report_and_stop();
    end

    // Well above the few hundred cycles the sequence needs
    initial begin
        #(40 * 20000);
        err_count++;
        report_and_stop();
    end
endmodule // tb_lcs_link_ctrl
`default_nettype wire
